/* common/lto_pkg.sv */
package lto_pkg;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] LTO_OFS_CTRL = 8'h00;
    localparam logic [7:0] LTO_OFS_PULSE = 8'h04;
    localparam logic [7:0] LTO_OFS_UP1_LO = 8'h08;
    localparam logic [7:0] LTO_OFS_UP1_HI = 8'h0c;
    localparam logic [7:0] LTO_OFS_LO1_LO = 8'h10;
    localparam logic [7:0] LTO_OFS_LO1_HI = 8'h14;
    localparam logic [7:0] LTO_OFS_UP2_LO = 8'h18;
    localparam logic [7:0] LTO_OFS_UP2_HI = 8'h1c;
    localparam logic [7:0] LTO_OFS_LO2_LO = 8'h20;
    localparam logic [7:0] LTO_OFS_LO2_HI = 8'h24;
    localparam logic [7:0] LTO_OFS_RESULT = 8'h28;
    localparam logic [7:0] LTO_OFS_CLEAR = 8'h2c;
    localparam logic [7:0] LTO_OFS_IRQ_ST = 8'h30;
    localparam logic [7:0] LTO_OFS_IRQ_MASK = 8'h34;

    // ****************************************
    // control field positions
    // ****************************************
    localparam int LTO_CTRL_OUT_EN = 0;
    localparam int LTO_CTRL_PULSE_EN = 1;
    localparam int LTO_CTRL_POL_LOW = 2;
    localparam int LTO_CTRL_LATCH_EN = 3;
    localparam int LTO_CTRL_TEST_EN = 4;
    localparam int LTO_CTRL_AUTO_CLR = 6;
    localparam int LTO_CLR_MASTER = 2;

    // ****************************************
    // widths, resets, ranges
    // ****************************************
    localparam int LTO_VAL_W = 33;
    localparam int LTO_MS_W = 27;
    localparam int LTO_NTEST = 2;
    localparam int LTO_NLINE = 5;
    localparam int LTO_LINE_MASTER = 4;
    localparam logic [1:0] LTO_AUTO_CLR_RST = 2'h3;
    localparam logic [LTO_VAL_W-1:0] LTO_UP1_RST = 33'h000000001;
    localparam logic [LTO_VAL_W-1:0] LTO_LO1_RST = 33'h1ffffffff;
    localparam logic [LTO_VAL_W-1:0] LTO_UP2_RST = 33'h000000002;
    localparam logic [LTO_VAL_W-1:0] LTO_LO2_RST = 33'h1fffffffe;
    localparam logic [LTO_MS_W-1:0] LTO_PULSE_MS_MIN = 27'h0000001;
    localparam logic [LTO_MS_W-1:0] LTO_PULSE_MS_MAX = 27'h5f5e0ff;
    localparam logic [LTO_MS_W-1:0] LTO_PULSE_MS_RST = 27'h0000002;

    // ****************************************
    // timing
    // ****************************************
    localparam int LTO_CLK_PERIOD_NS = 25;
    localparam int LTO_PULSE_UNIT_NS = 1000000;
    localparam int LTO_CYC_PER_MS = LTO_PULSE_UNIT_NS / LTO_CLK_PERIOD_NS;

endpackage

/* rtl/lto_pulse.sv */
`timescale 1ns/1ps
module lto_pulse
    import lto_pkg::*;
#(
    parameter int CYC_PER_MS = LTO_CYC_PER_MS
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic pulse_en,
    input wire logic [LTO_MS_W-1:0] dur_ms,
    // condition in, line activity out
    input wire logic trig,
    output logic act
);

    typedef enum logic [1:0] {
        LTO_ST_IDLE = 2'b01,
        LTO_ST_RUN = 2'b10
    } lto_pstate_e;

    typedef struct packed {
        lto_pstate_e st;
        logic prev;
        logic [31:0] sub;
        logic [LTO_MS_W-1:0] ms;
        logic act;
    } lto_pulse_s;

    lto_pulse_s q, d;

    always_comb
    begin
        d = q;
        d.prev = trig;
        case (q.st)
            LTO_ST_IDLE:
            begin
                // a new condition edge starts one timed pulse
                if (pulse_en && trig && !q.prev)
                begin
                    d.st = LTO_ST_RUN;
                    d.sub = 32'(CYC_PER_MS - 1);
                    d.ms = dur_ms;
                end
            end
            LTO_ST_RUN:
            begin
                if (!pulse_en)
                    d.st = LTO_ST_IDLE;
                else if (q.sub == 32'h0)
                begin
                    d.sub = 32'(CYC_PER_MS - 1);
                    d.ms = q.ms - 1'b1;
                    if (q.ms == LTO_PULSE_MS_MIN)
                        d.st = LTO_ST_IDLE;
                end
                else
                    d.sub = q.sub - 1'b1;
            end
            default:
                d.st = LTO_ST_IDLE;
        endcase
        d.act = pulse_en ? (d.st == LTO_ST_RUN) : trig;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= '{st: LTO_ST_IDLE, default: '0};
        else
            q <= d;
    end

    assign act = q.act;

endmodule

/* rtl/lto_top.sv */
`timescale 1ns/1ps
// Functional notes
// - master limit latch can be enabled or disabled; off after reset
// - limit lines driven only while output enable set; enable reads back
// - pulsing mode selectable, off by default; condition gives a timed pulse
// - pulse time 0.001 to 99999.999 s, default 0.002 s
// - one polarity for all lines, high true by default
// - first test holds upper and lower bound, defaults 1 and -1
// - second test holds its own bounds, defaults 2 and -2
// - each test enabled separately, off by default, enable reads back
// - result read shows 1 for a failing test, 0 otherwise
// - clear request resets that test's high and low events
// - per-test auto clear, on by default; off keeps events until cleared
module lto_top
    import lto_pkg::*;
#(
    parameter int CYC_PER_MS = LTO_CYC_PER_MS
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // readings
    input wire logic reading_valid,
    input wire logic [LTO_VAL_W-1:0] reading_value,
    // limit lines: hi1, lo1, hi2, lo2, master
    output logic [LTO_NLINE-1:0] lim_line_o,
    output logic [LTO_NLINE-1:0] lim_line_oe,
    // interrupt
    output logic irq
);

    typedef struct packed {
        logic out_en;
        logic pulse_en;
        logic pol_low;
        logic latch_en;
        logic [LTO_NTEST-1:0] test_en;
        logic [LTO_NTEST-1:0] auto_clr;
        logic [LTO_MS_W-1:0] pulse_ms;
        logic [LTO_NTEST-1:0][LTO_VAL_W-1:0] upper;
        logic [LTO_NTEST-1:0][LTO_VAL_W-1:0] lower;
        logic [2*LTO_NTEST-1:0] evt;
        logic master;
        logic [2*LTO_NTEST-1:0] irq_st;
        logic [2*LTO_NTEST-1:0] irq_mask;
        logic [31:0] prdata;
        logic pslverr;
        logic [LTO_NLINE-1:0] line;
        logic [LTO_NLINE-1:0] oe;
    } lto_regs_s;

    lto_regs_s q, d;

    logic wr, rd_acc, setup;
    logic [LTO_NTEST-1:0] clr_req, hit_hi, hit_lo;
    logic [LTO_NLINE-1:0] cond, act;
    logic [31:0] rmux;
    logic mapped;
    logic [LTO_MS_W-1:0] ms_wr;

    assign wr = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign setup = psel && !penable;

    // ****************************************
    // limit comparison
    // ****************************************
    always_comb
    begin
        for (int t = 0; t < LTO_NTEST; t++)
        begin
            hit_hi[t] = reading_valid && q.test_en[t] &&
                ($signed(reading_value) > $signed(q.upper[t]));
            hit_lo[t] = reading_valid && q.test_en[t] &&
                ($signed(reading_value) < $signed(q.lower[t]));
            clr_req[t] = wr && (paddr == LTO_OFS_CLEAR) && pwdata[t];
        end
    end

    // ****************************************
    // read mux and pulse time clamp
    // ****************************************
    always_comb
    begin
        rmux = 32'h0;
        mapped = 1'b1;
        case (paddr)
            LTO_OFS_CTRL:
                rmux = {24'h0, q.auto_clr, q.test_en, q.latch_en,
                    q.pol_low, q.pulse_en, q.out_en};
            LTO_OFS_PULSE: rmux = {5'h0, q.pulse_ms};
            LTO_OFS_UP1_LO: rmux = q.upper[0][31:0];
            LTO_OFS_UP1_HI: rmux = {32{q.upper[0][32]}};
            LTO_OFS_LO1_LO: rmux = q.lower[0][31:0];
            LTO_OFS_LO1_HI: rmux = {32{q.lower[0][32]}};
            LTO_OFS_UP2_LO: rmux = q.upper[1][31:0];
            LTO_OFS_UP2_HI: rmux = {32{q.upper[1][32]}};
            LTO_OFS_LO2_LO: rmux = q.lower[1][31:0];
            LTO_OFS_LO2_HI: rmux = {32{q.lower[1][32]}};
            LTO_OFS_RESULT:
                rmux = {25'h0, q.master, q.evt,
                    |q.evt[3:2], |q.evt[1:0]};
            LTO_OFS_CLEAR: rmux = 32'h0;
            LTO_OFS_IRQ_ST: rmux = {28'h0, q.irq_st};
            LTO_OFS_IRQ_MASK: rmux = {28'h0, q.irq_mask};
            default: mapped = 1'b0;
        endcase
        // out-of-range pulse times are pulled to the nearest legal value
        if (pwdata[31:LTO_MS_W] != 5'h0 ||
            pwdata[LTO_MS_W-1:0] > LTO_PULSE_MS_MAX)
            ms_wr = LTO_PULSE_MS_MAX;
        else if (pwdata[LTO_MS_W-1:0] < LTO_PULSE_MS_MIN)
            ms_wr = LTO_PULSE_MS_MIN;
        else
            ms_wr = pwdata[LTO_MS_W-1:0];
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        d = q;
        if (setup)
        begin
            d.prdata = rmux;
            d.pslverr = !mapped;
        end
        if (wr)
        begin
            case (paddr)
                LTO_OFS_CTRL:
                begin
                    d.out_en = pwdata[LTO_CTRL_OUT_EN];
                    d.pulse_en = pwdata[LTO_CTRL_PULSE_EN];
                    d.pol_low = pwdata[LTO_CTRL_POL_LOW];
                    d.latch_en = pwdata[LTO_CTRL_LATCH_EN];
                    d.test_en = pwdata[LTO_CTRL_TEST_EN+:2];
                    d.auto_clr = pwdata[LTO_CTRL_AUTO_CLR+:2];
                end
                LTO_OFS_PULSE: d.pulse_ms = ms_wr;
                LTO_OFS_UP1_LO: d.upper[0][31:0] = pwdata;
                LTO_OFS_UP1_HI: d.upper[0][32] = pwdata[0];
                LTO_OFS_LO1_LO: d.lower[0][31:0] = pwdata;
                LTO_OFS_LO1_HI: d.lower[0][32] = pwdata[0];
                LTO_OFS_UP2_LO: d.upper[1][31:0] = pwdata;
                LTO_OFS_UP2_HI: d.upper[1][32] = pwdata[0];
                LTO_OFS_LO2_LO: d.lower[1][31:0] = pwdata;
                LTO_OFS_LO2_HI: d.lower[1][32] = pwdata[0];
                LTO_OFS_IRQ_MASK: d.irq_mask = pwdata[3:0];
                default: d.pslverr = q.pslverr;
            endcase
        end
        // events: clear, then auto-clear follows the reading, then set wins
        for (int t = 0; t < LTO_NTEST; t++)
        begin
            if (clr_req[t])
                d.evt[2*t+:2] = 2'h0;
            if (reading_valid && q.test_en[t] && q.auto_clr[t])
                d.evt[2*t+:2] = 2'h0;
            if (hit_hi[t])
                d.evt[2*t] = 1'b1;
            if (hit_lo[t])
                d.evt[2*t+1] = 1'b1;
        end
        // a read of the status word clears it; new events still land
        if (rd_acc && paddr == LTO_OFS_IRQ_ST)
            d.irq_st = '0;
        for (int t = 0; t < LTO_NTEST; t++)
            d.irq_st[2*t+:2] = d.irq_st[2*t+:2] | {hit_lo[t], hit_hi[t]};
        // master limit: any failing test, held while the latch is on
        if (q.latch_en)
            d.master = (q.master && !(wr && paddr == LTO_OFS_CLEAR &&
                pwdata[LTO_CLR_MASTER])) || (|d.evt);
        else
            d.master = |d.evt;
        d.line = act ^ {LTO_NLINE{q.pol_low}};
        d.oe = {LTO_NLINE{q.out_en}};
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.auto_clr <= LTO_AUTO_CLR_RST;
            q.pulse_ms <= LTO_PULSE_MS_RST;
            q.upper[0] <= LTO_UP1_RST;
            q.lower[0] <= LTO_LO1_RST;
            q.upper[1] <= LTO_UP2_RST;
            q.lower[1] <= LTO_LO2_RST;
        end
        else
            q <= d;
    end

    // ****************************************
    // per-line pulse shaping
    // ****************************************
    assign cond = {q.master, q.evt};

    for (genvar i = 0; i < LTO_NLINE; i++)
    begin : g_line
        lto_pulse #(
            .CYC_PER_MS(CYC_PER_MS)
        ) u_pulse (
            .pclk(pclk),
            .presetn(presetn),
            .pulse_en(q.pulse_en),
            .dur_ms(q.pulse_ms),
            .trig(cond[i]),
            .act(act[i])
        );
    end

    // zero wait states keep the slave simple; data was fetched in setup
    assign pready = 1'b1;
    assign prdata = q.prdata;
    assign pslverr = q.pslverr;
    assign lim_line_o = q.line;
    assign lim_line_oe = q.oe;
    assign irq = |(q.irq_st & q.irq_mask);

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_latch_hold: assert property (
        q.latch_en && q.master && !wr && $stable(q.latch_en) |=> q.master)
        else $error("master_latch_enable master limit dropped");

    chk_out_gate: assert property (
        !q.out_en |=> lim_line_oe == '0)
        else $error("limit lines driven while disabled");

    chk_level_mode: assert property (
        !q.pulse_en ##1 !q.pulse_en |-> act == $past(cond))
        else $error("level mode line does not follow condition");

    chk_pulse_range: assert property (
        q.pulse_ms >= LTO_PULSE_MS_MIN && q.pulse_ms <= LTO_PULSE_MS_MAX)
        else $error("pulse time out of range");

    chk_line_polarity: assert property (
        q.out_en |=>
        lim_line_o == ($past(act) ^ {LTO_NLINE{$past(q.pol_low)}}))
        else $error("limit line polarity wrong");

    chk_hi_event: assert property (
        reading_valid && q.test_en[0] &&
        $signed(reading_value) > $signed(q.upper[0])
        |=> q.evt[0] && q.irq_st[0])
        else $error("high event of first test not set");

    chk_lo_event: assert property (
        reading_valid && q.test_en[1] &&
        $signed(reading_value) < $signed(q.lower[1]) |=> q.evt[3])
        else $error("low event of second test not set");

    chk_disabled_still: assert property (
        !q.test_en[0] && !clr_req[0] |=> $stable(q.evt[1:0]))
        else $error("disabled test changed its events");

    chk_fail_read: assert property (
        setup && paddr == LTO_OFS_RESULT |=>
        prdata[1:0] == {|$past(q.evt[3:2]), |$past(q.evt[1:0])})
        else $error("result read mismatch");

    chk_clear_evt: assert property (
        clr_req[1] && !reading_valid |=> q.evt[3:2] == 2'h0)
        else $error("clear left events set");

    chk_sticky_evt: assert property (
        q.evt[0] && !q.auto_clr[0] && !clr_req[0] |=> q.evt[0])
        else $error("event lost without clear");

    chk_master_free: assert property (
        !q.latch_en |=> q.master == |q.evt)
        else $error("unlatched master does not follow events");

    chk_out_drive: assert property (
        q.out_en |=> lim_line_oe == '1)
        else $error("limit lines not driven while enabled");

    // a running pulse ignores new edges, so only an idle line is held to it
    chk_pulse_start: assert property (
        q.pulse_en && $past(q.pulse_en) && !act[0] && $rose(cond[0])
        |=> act[0])
        else $error("condition edge gave no pulse");

    chk_pulse_clamp: assert property (
        wr && paddr == LTO_OFS_PULSE && pwdata == 32'h0
        |=> q.pulse_ms == LTO_PULSE_MS_MIN)
        else $error("zero pulse time not raised to floor");

    // half-written bounds are visible to the compare; nothing else moves them
    chk_bounds_hold: assert property (
        !wr |=> $stable(q.upper) && $stable(q.lower))
        else $error("bounds changed without a write");

    chk_auto_replace: assert property (
        reading_valid && q.test_en[1] && q.auto_clr[1] &&
        !hit_hi[1] && !hit_lo[1] |=> q.evt[3:2] == 2'h0)
        else $error("auto clear kept a stale event");

    // a reading in the same cycle may set a bit again, so keep it out
    chk_status_read: assert property (
        rd_acc && paddr == LTO_OFS_IRQ_ST && !reading_valid
        |=> q.irq_st == '0)
        else $error("status read did not clear");

    chk_unaligned_err: assert property (
        setup && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("unaligned access not refused");

    cov_pulse: cover property (q.pulse_en && $rose(act[0]) ##1 act[0][*3]);
    cov_master_latch_enable: cover property (q.latch_en && q.master && q.evt == '0);
    cov_irq: cover property ($rose(irq));
    cov_both_fail: cover property (q.evt[0] && q.evt[3]);
    cov_sticky: cover property (!q.auto_clr[0] && q.evt[1:0] == 2'h3);

endmodule

/* tb/lto_line_watch.sv */
`timescale 1ns/1ps
// ****************************************
// far side: equipment watching limit lines
// ****************************************
module lto_line_watch
    import lto_pkg::*;
(
    // clock
    input wire logic pclk,
    // limit lines as driven
    input wire logic [LTO_NLINE-1:0] lim_line_o,
    input wire logic [LTO_NLINE-1:0] lim_line_oe,
    // what the equipment sees
    output logic [LTO_NLINE-1:0] seen,
    output int run_len
);
    int cnt = 0;

    // undriven lines are pulled down at the receiver
    assign seen = lim_line_o & lim_line_oe;

    // width of the last high run on line 0
    always @(posedge pclk)
    begin
        if (seen[0])
            cnt <= cnt + 1;
        else
        begin
            if (cnt != 0)
                run_len <= cnt;
            cnt <= 0;
        end
    end
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench
    import lto_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic reading_valid = 1'b0;
    logic [LTO_VAL_W-1:0] reading_value = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [LTO_NLINE-1:0] lim_line_o;
    logic [LTO_NLINE-1:0] lim_line_oe;
    logic irq;
    logic [LTO_NLINE-1:0] seen;
    int run_len;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [31:0] r;
    logic e;
    logic [7:0] ra [10] = '{LTO_OFS_CTRL, LTO_OFS_PULSE, LTO_OFS_UP1_LO,
        LTO_OFS_UP1_HI, LTO_OFS_LO1_LO, LTO_OFS_LO1_HI, LTO_OFS_UP2_LO,
        LTO_OFS_UP2_HI, LTO_OFS_LO2_LO, LTO_OFS_LO2_HI};
    logic [31:0] rv [10] = '{32'h000000c0, 32'h00000002, 32'h00000001,
        32'h00000000, 32'hffffffff, 32'hffffffff, 32'h00000002,
        32'h00000000, 32'hfffffffe, 32'hffffffff};

    // short pulse count keeps the pulse test quick
    lto_top #(.CYC_PER_MS(4)) i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reading_valid(reading_valid),
        .reading_value(reading_value), .lim_line_o(lim_line_o),
        .lim_line_oe(lim_line_oe), .irq(irq));

    lto_line_watch i_watch (.pclk(pclk), .lim_line_o(lim_line_o),
        .lim_line_oe(lim_line_oe), .seen(seen), .run_len(run_len));

    always #12.5 pclk = ~pclk;

    // ****************************************
    // tasks
    // ****************************************
    task automatic results();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string m);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] x,
        input string m);
        apb(1'b0, a, 32'h00000000);
        chk(r, x, m);
    endtask

    // one reading, then time for events and lines to settle
    task automatic rdg(input logic [LTO_VAL_W-1:0] v);
        @(posedge pclk);
        reading_valid <= 1'b1;
        reading_value <= v;
        @(posedge pclk);
        reading_valid <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask

    // ****************************************
    // hang guard
    // ****************************************
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            $display("mismatch at %0t: timeout", $time);
            error_cnt++;
            results();
        end
    end

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 10; i++)
            rdc(ra[i], rv[i], "reset");
        apb(1'b0, 8'h3e, 32'h00000000);
        chk({31'h0, e}, 32'h00000001, "unmapped error");
        chk(r, 32'h00000000, "unmapped data");
        rdg(33'd5);
        rdc(LTO_OFS_RESULT, 32'h00000000, "disabled test");
        wr(LTO_OFS_CTRL, 32'h000000d0);
        rdg(33'd5);
        rdc(LTO_OFS_RESULT, 32'h00000045, "high event");
        chk({27'h0, seen}, 32'h00000000, "lines undriven");
        chk({31'h0, irq}, 32'h00000000, "irq masked");
        wr(LTO_OFS_IRQ_MASK, 32'h0000000f);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h00000001, "irq raised");
        rdc(LTO_OFS_IRQ_ST, 32'h00000001, "irq status");
        @(posedge pclk);
        chk({31'h0, irq}, 32'h00000000, "irq cleared");
        wr(LTO_OFS_CTRL, 32'h000000d1);
        repeat (4) @(posedge pclk);
        chk({27'h0, seen}, 32'h00000011, "lines driven");
        rdc(LTO_OFS_CTRL, 32'h000000d1, "ctrl readback");
        rdg(-33'sd5);
        rdc(LTO_OFS_RESULT, 32'h00000049, "low event");
        wr(LTO_OFS_CTRL, 32'h000000d5);
        repeat (4) @(posedge pclk);
        chk({27'h0, seen}, 32'h0000000d, "low true lines");
        wr(LTO_OFS_CTRL, 32'h00000091);
        rdg(33'd5);
        rdc(LTO_OFS_RESULT, 32'h0000004d, "sticky events");
        wr(LTO_OFS_CLEAR, 32'h00000001);
        rdc(LTO_OFS_RESULT, 32'h00000000, "events cleared");
        wr(LTO_OFS_CTRL, 32'h000000d9);
        rdg(33'd5);
        rdg(33'd0);
        rdc(LTO_OFS_RESULT, 32'h00000040, "master master_latch_enable");
        wr(LTO_OFS_CLEAR, 32'h00000004);
        rdc(LTO_OFS_RESULT, 32'h00000000, "latch cleared");
        wr(LTO_OFS_PULSE, 32'h00000000);
        rdc(LTO_OFS_PULSE, 32'h00000001, "pulse floor");
        wr(LTO_OFS_CTRL, 32'h000000d3);
        rdg(33'd5);
        repeat (10) @(posedge pclk);
        chk(run_len, 32'h00000004, "pulse width");
        wr(LTO_OFS_CTRL, 32'h000000e0);
        wr(LTO_OFS_CLEAR, 32'h00000003);
        wr(LTO_OFS_UP2_LO, 32'h0000000a);
        rdc(LTO_OFS_UP2_LO, 32'h0000000a, "bound readback");
        rdg(33'd11);
        rdc(LTO_OFS_RESULT, 32'h00000052, "second high");
        rdg(-33'sd3);
        rdc(LTO_OFS_RESULT, 32'h00000062, "second low");
        rdg(-33'sd2);
        rdc(LTO_OFS_RESULT, 32'h00000000, "on the bound");
        wr(LTO_OFS_PULSE, 32'hffffffff);
        rdc(LTO_OFS_PULSE, 32'h05f5e0ff, "pulse ceiling");
        results();
    end
endmodule
